/* inc/cmr_pkg.sv */
// Summary of operation
// - A copy-file-register op with the destination bit clear loads the file register into the accumulator.
// - A copy-file-register op with the destination bit set writes the value back into the same file register.
// - A copy-file-register op updates the result-null flag from the moved value.
// - A store-accumulator op writes the accumulator into the file register at the 7-bit address and keeps all flags.
// - A load-literal op puts its 8-bit immediate into the accumulator and keeps all flags.
// - A return-with-literal op loads its 8-bit immediate into the accumulator and pops the return stack.
// - A return-with-literal op loads the program counter from the popped stack top and keeps all flags.
// - A return-with-literal op takes two instruction cycles.
// - A rotate-left op shifts toward bit 7, the old rotate-out flag enters bit 0 and old bit 7 becomes the flag.
// - A rotate-left op writes the accumulator when the destination bit is 0, else the file register, and changes only the rotate-out flag.
// - A sleep op clears the power-down flag.
// - A sleep op sets the watchdog-expiry flag.
// - A sleep op clears the watchdog counter and its prescaler.
// - After a sleep op the core halts in the sleep state with its oscillator stopped.
// - A plain return pops the stack into the program counter and takes two instruction cycles.
package cmr_pkg;

  // ----------------------------------------------------------------------
  // Opcode word layout and operation codes
  // ----------------------------------------------------------------------
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 12;
  localparam int DEST_BIT = 8;
  localparam int FADDR_MSB = 6;
  localparam int LIT_MSB = 7;
  localparam logic [3:0] OP_IDLE = 4'h0;
  localparam logic [3:0] OP_COPY = 4'h1;
  localparam logic [3:0] OP_STORE = 4'h2;
  localparam logic [3:0] OP_LOAD = 4'h3;
  localparam logic [3:0] OP_RETLIT = 4'h4;
  localparam logic [3:0] OP_IRQRET = 4'h5;
  localparam logic [3:0] OP_ROTL = 4'h6;
  localparam logic [3:0] OP_SLEEP = 4'h7;
  localparam logic [3:0] OP_RETURN = 4'h8;

  // ----------------------------------------------------------------------
  // Bus map: word index = haddr[8:2], file window when haddr[9] is set
  // ----------------------------------------------------------------------
  localparam int ADDR_TOP_LSB = 10;
  localparam int ADDR_FILE_BIT = 9;
  localparam logic [6:0] IDX_OPCODE = 7'h00;
  localparam logic [6:0] IDX_ACC = 7'h01;
  localparam logic [6:0] IDX_STATUS = 7'h02;
  localparam logic [6:0] IDX_PC = 7'h03;
  localparam logic [6:0] IDX_STACK = 7'h04;
  localparam logic [6:0] IDX_WDOG = 7'h05;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACTIVE_BIT = 1;

  // ----------------------------------------------------------------------
  // Status word bits and stack read layout
  // ----------------------------------------------------------------------
  localparam int ST_CARRY = 0;
  localparam int ST_ZERO = 2;
  localparam int ST_PDOWN = 3;
  localparam int ST_WEXP = 4;
  localparam int ST_SLEEP = 6;
  localparam int ST_GIRQ = 7;
  localparam int ST_WAKE = 8;
  localparam int STACK_SP_LSB = 16;
  localparam logic [12:0] PC_STEP = 13'h0001;
  localparam logic [2:0] SP_STEP = 3'h1;
  localparam logic [7:0] WD_STEP = 8'h01;
  localparam logic [7:0] WD_PRE_LAST = 8'hFF;

  typedef enum logic [1:0] {
    CORE_IDLE = 2'b00,
    CORE_EXEC = 2'b01,
    CORE_FLUSH = 2'b10,
    CORE_SLEEP = 2'b11
  } cmr_core_e;

  typedef struct packed {
    cmr_core_e core;
    logic [15:0] opcode;
    logic [7:0] acc;
    logic carry;
    logic zero;
    logic power_down_flag;
    logic watchdog_expiry_flag;
    logic global_irq_allow;
    logic [12:0] pc;
    logic [2:0] sp;
    logic [7:0][12:0] stack;
    logic [127:0][7:0] file;
    logic [7:0] watchdog_counter;
    logic [7:0] wd_prescale;
    logic osc_run;
    logic dp_valid;
    logic dp_write;
    logic dp_map;
    logic dp_file;
    logic [6:0] dp_idx;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
  } cmr_state_s;

  localparam cmr_state_s ST_RESET = '{core: CORE_IDLE, power_down_flag: 1'b1,
    watchdog_expiry_flag: 1'b1, osc_run: 1'b1, hready: 1'b1, default: '0};

endpackage : cmr_pkg

/* verilog/cmr_core.sv */
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module cmr_core (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic osc_run
);

  cmr_pkg::cmr_state_s st_ff;
  cmr_pkg::cmr_state_s nxt_st;

  // ----------------------------------------------------------------------
  // Opcode fields of the instruction held for execution
  // ----------------------------------------------------------------------
  logic [3:0] op;
  logic dest_file;
  logic [6:0] faddr;
  logic [7:0] lit;
  logic [7:0] src_val;
  logic [2:0] sp_pop;
  logic [12:0] stack_top;
  logic [7:0] rot_val;
  logic busy;
  logic [3:0] flags;

  // Decoded fields are shared by the execution logic and the checks below.
  assign op = st_ff.opcode[cmr_pkg::OPC_MSB:cmr_pkg::OPC_LSB];
  assign dest_file = st_ff.opcode[cmr_pkg::DEST_BIT];
  assign faddr = st_ff.opcode[cmr_pkg::FADDR_MSB:0];
  assign lit = st_ff.opcode[cmr_pkg::LIT_MSB:0];
  assign src_val = st_ff.file[faddr];
  assign sp_pop = st_ff.sp - cmr_pkg::SP_STEP;
  assign stack_top = st_ff.stack[sp_pop];
  assign rot_val = {src_val[6:0], st_ff.carry};
  assign busy = (st_ff.core == cmr_pkg::CORE_EXEC) || (st_ff.core == cmr_pkg::CORE_FLUSH);
  assign flags = {st_ff.carry, st_ff.zero, st_ff.power_down_flag, st_ff.watchdog_expiry_flag};

  // ----------------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------------
  // Unmapped or wrongly sized reads return zero with an OKAY response.
  function automatic logic [31:0] read_word(input cmr_pkg::cmr_state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (s.dp_map && s.dp_file) begin
      w[7:0] = s.file[s.dp_idx];
    end else if (s.dp_map) begin
      case (s.dp_idx)
        cmr_pkg::IDX_OPCODE: w[15:0] = s.opcode;
        cmr_pkg::IDX_ACC: w[7:0] = s.acc;
        cmr_pkg::IDX_STATUS: begin
          w[cmr_pkg::ST_CARRY] = s.carry;
          w[cmr_pkg::ST_ZERO] = s.zero;
          w[cmr_pkg::ST_PDOWN] = s.power_down_flag;
          w[cmr_pkg::ST_WEXP] = s.watchdog_expiry_flag;
          w[cmr_pkg::ST_SLEEP] = (s.core == cmr_pkg::CORE_SLEEP);
          w[cmr_pkg::ST_GIRQ] = s.global_irq_allow;
        end
        cmr_pkg::IDX_PC: w[12:0] = s.pc;
        cmr_pkg::IDX_STACK: begin
          w[12:0] = s.stack[s.sp - cmr_pkg::SP_STEP];
          w[cmr_pkg::STACK_SP_LSB +: 3] = s.sp;
        end
        cmr_pkg::IDX_WDOG: w[7:0] = s.watchdog_counter;
        default: w = 32'h0000_0000;
      endcase
    end
    return w;
  endfunction : read_word

  // ----------------------------------------------------------------------
  // Next-state logic: watchdog, execution, then bus
  // ----------------------------------------------------------------------
  // Execution runs first so that the bus sees the core's next state when it
  // decides whether a new access may finish without a wait state.
  always_comb begin
    nxt_st = st_ff;

    // The watchdog only counts while the oscillator runs.
    if (st_ff.core != cmr_pkg::CORE_SLEEP) begin
      nxt_st.wd_prescale = st_ff.wd_prescale + cmr_pkg::WD_STEP;
      if (st_ff.wd_prescale == cmr_pkg::WD_PRE_LAST) begin
        nxt_st.watchdog_counter = st_ff.watchdog_counter + cmr_pkg::WD_STEP;
      end
    end

    // A two-cycle op spends its second cycle here while the fetch refills.
    if (st_ff.core == cmr_pkg::CORE_FLUSH) begin
      nxt_st.core = cmr_pkg::CORE_IDLE;
    end

    if (st_ff.core == cmr_pkg::CORE_EXEC) begin
      nxt_st.core = cmr_pkg::CORE_IDLE;
      nxt_st.pc = st_ff.pc + cmr_pkg::PC_STEP;
      case (op)
        cmr_pkg::OP_COPY: begin
          if (dest_file) begin
            nxt_st.file[faddr] = src_val;
          end else begin
            nxt_st.acc = src_val;
          end
          nxt_st.zero = (src_val == 8'h00);
        end
        cmr_pkg::OP_STORE: begin
          nxt_st.file[faddr] = st_ff.acc;
        end
        cmr_pkg::OP_LOAD: begin
          nxt_st.acc = lit;
        end
        cmr_pkg::OP_RETLIT: begin
          nxt_st.acc = lit;
          nxt_st.sp = sp_pop;
          nxt_st.pc = stack_top;
          nxt_st.core = cmr_pkg::CORE_FLUSH;
        end
        cmr_pkg::OP_IRQRET: begin
          nxt_st.sp = sp_pop;
          nxt_st.pc = stack_top;
          nxt_st.global_irq_allow = 1'b1;
          nxt_st.core = cmr_pkg::CORE_FLUSH;
        end
        cmr_pkg::OP_RETURN: begin
          nxt_st.sp = sp_pop;
          nxt_st.pc = stack_top;
          nxt_st.core = cmr_pkg::CORE_FLUSH;
        end
        cmr_pkg::OP_ROTL: begin
          nxt_st.carry = src_val[7];
          if (dest_file) begin
            nxt_st.file[faddr] = rot_val;
          end else begin
            nxt_st.acc = rot_val;
          end
        end
        cmr_pkg::OP_SLEEP: begin
          nxt_st.power_down_flag = 1'b0;
          nxt_st.watchdog_expiry_flag = 1'b1;
          nxt_st.watchdog_counter = 8'h00;
          nxt_st.wd_prescale = 8'h00;
          nxt_st.core = cmr_pkg::CORE_SLEEP;
        end
        default: begin
          // Idle and undefined codes only advance the program counter.
          nxt_st.core = cmr_pkg::CORE_IDLE;
        end
      endcase
    end

    // Data phase finishing at this edge; writes happen only while the core is
    // not executing, so no flag can be set and written in the same cycle.
    if (st_ff.dp_valid && st_ff.hready) begin
      nxt_st.dp_valid = 1'b0;
      if (st_ff.dp_write && st_ff.dp_map && st_ff.dp_file) begin
        nxt_st.file[st_ff.dp_idx] = hwdata[7:0];
      end else if (st_ff.dp_write && st_ff.dp_map) begin
        case (st_ff.dp_idx)
          cmr_pkg::IDX_OPCODE: begin
            nxt_st.opcode = hwdata[15:0];
            // A halted core ignores new opcodes until it is woken.
            if (st_ff.core != cmr_pkg::CORE_SLEEP) begin
              nxt_st.core = cmr_pkg::CORE_EXEC;
            end
          end
          cmr_pkg::IDX_ACC: nxt_st.acc = hwdata[7:0];
          cmr_pkg::IDX_STATUS: begin
            nxt_st.carry = hwdata[cmr_pkg::ST_CARRY];
            nxt_st.zero = hwdata[cmr_pkg::ST_ZERO];
            nxt_st.global_irq_allow = hwdata[cmr_pkg::ST_GIRQ];
            if (hwdata[cmr_pkg::ST_WAKE] && (st_ff.core == cmr_pkg::CORE_SLEEP)) begin
              nxt_st.core = cmr_pkg::CORE_IDLE;
            end
          end
          cmr_pkg::IDX_PC: nxt_st.pc = hwdata[12:0];
          cmr_pkg::IDX_STACK: begin
            // Pushes wrap round like the hardware return stack.
            nxt_st.stack[st_ff.sp] = hwdata[12:0];
            nxt_st.sp = st_ff.sp + cmr_pkg::SP_STEP;
          end
          default: nxt_st.sp = st_ff.sp;
        endcase
      end
    end

    // Wait state: present read data once the core has gone quiet.
    if (!nxt_st.dp_valid) begin
      nxt_st.hready = 1'b1;
    end else if (!st_ff.hready && !busy) begin
      nxt_st.hready = 1'b1;
      if (!st_ff.dp_write) begin
        nxt_st.hrdata = read_word(st_ff);
      end
    end

    // Address phase accepted; a write finishes at once if the core is quiet.
    if (hsel && htrans[cmr_pkg::HTRANS_ACTIVE_BIT] && hready) begin
      nxt_st.dp_valid = 1'b1;
      nxt_st.dp_write = hwrite;
      nxt_st.dp_file = haddr[cmr_pkg::ADDR_FILE_BIT];
      nxt_st.dp_idx = haddr[8:2];
      nxt_st.dp_map = (haddr[31:cmr_pkg::ADDR_TOP_LSB] == 22'h00_0000) &&
                      (haddr[1:0] == 2'h0) && (hsize == cmr_pkg::HSIZE_WORD);
      nxt_st.hready = hwrite && (nxt_st.core != cmr_pkg::CORE_EXEC) &&
                      (nxt_st.core != cmr_pkg::CORE_FLUSH);
    end

    nxt_st.osc_run = (nxt_st.core != cmr_pkg::CORE_SLEEP);
    nxt_st.hresp = 1'b0;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= cmr_pkg::ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output is a field of the state register.
  assign hreadyout = st_ff.hready;
  assign hrdata = st_ff.hrdata;
  assign hresp = st_ff.hresp;
  assign osc_run = st_ff.osc_run;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_exec(logic [3:0] code);
    (st_ff.core == cmr_pkg::CORE_EXEC) && (op == code);
  endsequence

  sequence s_two_cycle_end;
    (st_ff.core == cmr_pkg::CORE_FLUSH) ##1 (st_ff.core == cmr_pkg::CORE_IDLE);
  endsequence

  a_copy_to_acc: assert property (s_exec(cmr_pkg::OP_COPY) and !dest_file
    |=> (st_ff.acc == $past(src_val)) && $stable(st_ff.file))
    else $error("Copy to accumulator lost the file value.");

  a_copy_to_file: assert property (s_exec(cmr_pkg::OP_COPY) and dest_file
    |=> $stable(st_ff.file) && $stable(st_ff.acc))
    else $error("Copy onto itself altered state.");

  a_copy_zero: assert property (s_exec(cmr_pkg::OP_COPY)
    |=> st_ff.zero == ($past(src_val) == 8'h00))
    else $error("Result-null flag wrong after copy.");

  a_store_acc: assert property (s_exec(cmr_pkg::OP_STORE)
    |=> (st_ff.file[$past(faddr)] == $past(st_ff.acc)) && $stable(flags))
    else $error("Store of accumulator failed.");

  a_load_lit: assert property (s_exec(cmr_pkg::OP_LOAD)
    |=> (st_ff.acc == $past(lit)) && $stable(flags))
    else $error("Literal load failed.");

  a_retlit_pop: assert property (s_exec(cmr_pkg::OP_RETLIT)
    |=> (st_ff.acc == $past(lit)) && (st_ff.pc == $past(stack_top))
        && (st_ff.sp == $past(sp_pop)) && $stable(flags))
    else $error("Return with literal did not pop correctly.");

  a_retlit_two: assert property (s_exec(cmr_pkg::OP_RETLIT) |=> s_two_cycle_end)
    else $error("Return with literal is not two cycles.");

  a_rotate_left: assert property (s_exec(cmr_pkg::OP_ROTL)
    |=> (st_ff.carry == $past(src_val[7])) && ($past(dest_file)
        ? (st_ff.file[$past(faddr)] == $past(rot_val))
        : (st_ff.acc == $past(rot_val))) && (st_ff.zero == $past(st_ff.zero)))
    else $error("Rotate left result or carry wrong.");

  a_sleep_entry: assert property (s_exec(cmr_pkg::OP_SLEEP)
    |=> !st_ff.power_down_flag && st_ff.watchdog_expiry_flag
        && (st_ff.watchdog_counter == 8'h00) && (st_ff.wd_prescale == 8'h00)
        && (st_ff.core == cmr_pkg::CORE_SLEEP) && !osc_run)
    else $error("Sleep entry effects missing.");

  a_irq_return: assert property (s_exec(cmr_pkg::OP_IRQRET)
    |=> st_ff.global_irq_allow && (st_ff.pc == $past(stack_top)) && $stable(flags))
    else $error("Interrupt return failed.");

  a_idle_step: assert property (s_exec(cmr_pkg::OP_IDLE)
    |=> (st_ff.pc == $past(st_ff.pc) + cmr_pkg::PC_STEP) && $stable(st_ff.acc)
        && $stable(st_ff.file) && $stable(flags) && (st_ff.core == cmr_pkg::CORE_IDLE))
    else $error("Idle op changed state or took too long.");

  a_plain_return: assert property (s_exec(cmr_pkg::OP_RETURN)
    |=> (st_ff.pc == $past(stack_top)) ##0 s_two_cycle_end)
    else $error("Plain return failed.");

  // ----------------------------------------------------------------------
  // Checks on the halted core, the watchdog and the bus
  // ----------------------------------------------------------------------
  // An address phase that asks for a read of any register.
  sequence s_read_addr;
    hsel && htrans[cmr_pkg::HTRANS_ACTIVE_BIT] && hready && !hwrite;
  endsequence

  // Codes beyond the last defined one must act exactly like the idle op.
  a_undef_idle: assert property ((st_ff.core == cmr_pkg::CORE_EXEC)
    && (op > cmr_pkg::OP_RETURN)
    |=> (st_ff.pc == $past(st_ff.pc) + cmr_pkg::PC_STEP) && $stable(st_ff.acc)
        && $stable(st_ff.file) && $stable(flags) && (st_ff.core == cmr_pkg::CORE_IDLE))
    else $error("Undefined op did more than an idle op.");

  // A stopped oscillator means the watchdog must not move at all.
  a_wdog_frozen: assert property ((st_ff.core == cmr_pkg::CORE_SLEEP)
    |=> $stable(st_ff.watchdog_counter) && $stable(st_ff.wd_prescale))
    else $error("Watchdog moved while asleep.");

  // An opcode written while asleep is kept but must never start running.
  a_sleep_hold: assert property ((st_ff.core == cmr_pkg::CORE_SLEEP)
    |=> (st_ff.core != cmr_pkg::CORE_EXEC))
    else $error("Halted core started executing.");

  // While idle the counter advances once each time the prescaler wraps.
  a_wdog_tick: assert property ((st_ff.wd_prescale == cmr_pkg::WD_PRE_LAST)
    && (st_ff.core == cmr_pkg::CORE_IDLE)
    |=> st_ff.watchdog_counter == $past(st_ff.watchdog_counter) + cmr_pkg::WD_STEP)
    else $error("Watchdog missed a prescaler wrap.");

  // Writes wait out execution; otherwise a software flag write could race the
  // hardware update of the same flag in one cycle.
  a_quiet_write: assert property (busy |-> !(st_ff.dp_valid && st_ff.hready))
    else $error("Data phase finished while the core was executing.");

  // Reads always insert one wait state, and at most three behind a return.
  a_read_wait: assert property (s_read_addr |=> !hreadyout ##[1:3] hreadyout)
    else $error("Read wait states out of range.");

endmodule : cmr_core
`default_nettype wire

/* testbench/cpu_move_return_rotate_sleep_ops_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module cpu_move_return_rotate_sleep_ops_tb_top;
  logic core_clk, nrst, hsel, hwrite, hreadyout, hresp, osc_run;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] lfsr;
  int fails, check_count, last_wait, ex_wait, w_idle, f, k;
  int m_acc, m_c, m_z, m_pd, m_to, m_gie, m_slp, m_pc, m_sp;
  int m_stk[8];
  int m_file[128];

  // The single slave's ready is fed straight back as the bus ready.
  cmr_core u_dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .osc_run(osc_run));

  // ------------------------------------------------------------------
  // Clock, helpers and bus master
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd

  function automatic logic [31:0] ra(input logic [6:0] idx);
    return {23'h0, idx, 2'b00};
  endfunction : ra

  // Waits as long as the slave stalls; only the run's watchdog ends a hang.
  task automatic wait_rdy();
    last_wait = 0;
    do begin
      @(posedge core_clk);
      last_wait++;
    end while (hreadyout !== 1'b1);
    if (last_wait >= 50) `CHK("bus ready", 1, 0);
  endtask : wait_rdy

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= cmr_pkg::HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : ahb

  // ------------------------------------------------------------------
  // Reference model and checks
  // ------------------------------------------------------------------
  task automatic pop();
    m_sp = (m_sp + 7) % 8;
    m_pc = m_stk[m_sp];
  endtask : pop

  task automatic check_all(input int fa);
    ahb(1'b0, ra(cmr_pkg::IDX_ACC), 32'h0);
    `CHK("acc", m_acc, rd);
    ahb(1'b0, ra(cmr_pkg::IDX_STATUS), 32'h0);
    `CHK("status", m_c | m_z << 2 | m_pd << 3 | m_to << 4 | m_slp << 6 | m_gie << 7, rd[7:0]);
    ahb(1'b0, ra(cmr_pkg::IDX_STACK), 32'h0);
    `CHK("stack", m_sp << 16 | m_stk[(m_sp + 7) % 8], rd);
    ahb(1'b0, 32'h200 | 32'(fa << 2), 32'h0);
    `CHK("file", m_file[fa], rd);
  endtask : check_all

  task automatic wr_status(input int c, input int z, input int g, input int wake);
    m_c = c;
    m_z = z;
    m_gie = g;
    ahb(1'b1, ra(cmr_pkg::IDX_STATUS), 32'(c | z << 2 | g << 7 | wake << 8));
  endtask : wr_status

  // Issues one opcode, then a read that stalls until execution ends; the
  // stall length reveals the instruction's cycle count.
  task automatic exec(input logic [3:0] op, input int d, input int kk);
    int v;
    ahb(1'b1, ra(cmr_pkg::IDX_OPCODE), {16'h0, op, 3'b000, 1'(d), 8'(kk)});
    ahb(1'b0, ra(cmr_pkg::IDX_PC), 32'h0);
    ex_wait = last_wait;
    v = m_file[kk % 128];
    m_pc = (m_pc + 1) % 8192;
    case (op)
      cmr_pkg::OP_COPY: begin
        if (d != 0) m_file[kk % 128] = v;
        else m_acc = v;
        m_z = (v == 0);
      end
      cmr_pkg::OP_STORE: m_file[kk % 128] = m_acc;
      cmr_pkg::OP_LOAD: m_acc = kk;
      cmr_pkg::OP_RETLIT: begin
        m_acc = kk;
        pop();
      end
      cmr_pkg::OP_IRQRET: begin
        m_gie = 1;
        pop();
      end
      cmr_pkg::OP_ROTL: begin
        v = (v << 1) | m_c;
        m_c = v >> 8;
        v = v & 255;
      end
      cmr_pkg::OP_SLEEP: begin
        m_pd = 0;
        m_to = 1;
        m_slp = 1;
      end
      cmr_pkg::OP_RETURN: pop();
      default: ;
    endcase
    if (op == cmr_pkg::OP_ROTL) begin
      if (d != 0) m_file[kk % 128] = v;
      else m_acc = v;
    end
    `CHK("pc", m_pc, rd);
    check_all(kk % 128);
  endtask : exec

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    lfsr = 16'd55387;
    {m_acc, m_c, m_z, m_gie, m_slp, m_pc, m_sp} = '0;
    m_pd = 1;
    m_to = 1;
    m_stk = '{default: 0};
    m_file = '{default: 0};
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    `CHK("osc after reset", 1, osc_run);
    check_all(0);
    $display("test reset done");
    // Boundary addresses 0 and 127 and literals 0 and 255 come first.
    for (int i = 0; i < 6; i++) begin
      f = (i == 0) ? 0 : (i == 1) ? 127 : rnd() % 128;
      k = (i == 2) ? 0 : (i == 3) ? 255 : rnd() % 256;
      m_file[f] = rnd() % 256;
      ahb(1'b1, 32'h200 | 32'(f << 2), 32'(m_file[f]));
      wr_status(rnd() % 2, rnd() % 2, 0, 0);
      exec(cmr_pkg::OP_LOAD, 0, k);
      exec(cmr_pkg::OP_STORE, 0, f);
      exec(cmr_pkg::OP_LOAD, 0, ~k & 255);
      exec(cmr_pkg::OP_COPY, 1, f);
      exec(cmr_pkg::OP_COPY, 0, f);
    end
    $display("test moves done");
    for (int i = 0; i < 4; i++) begin
      f = rnd() % 128;
      m_file[f] = (i == 0) ? 8'h80 : rnd() % 256;
      ahb(1'b1, 32'h200 | 32'(f << 2), 32'(m_file[f]));
      wr_status(i % 2, rnd() % 2, 0, 0);
      exec(cmr_pkg::OP_ROTL, i / 2, f);
    end
    $display("test rotate done");
    for (int i = 0; i < 3; i++) begin
      m_stk[m_sp] = rnd() % 8192;
      ahb(1'b1, ra(cmr_pkg::IDX_STACK), 32'(m_stk[m_sp]));
      m_sp = (m_sp + 1) % 8;
    end
    exec(cmr_pkg::OP_IDLE, 0, 0);
    w_idle = ex_wait;
    exec(4'hF, 1, 5);
    `CHK("undefined op cycles", w_idle, ex_wait);
    exec(cmr_pkg::OP_RETLIT, 0, rnd() % 256);
    `CHK("retlit cycles", w_idle + 1, ex_wait);
    wr_status(1, 1, 0, 0);
    exec(cmr_pkg::OP_IRQRET, 0, 0);
    `CHK("irqret cycles", w_idle + 1, ex_wait);
    exec(cmr_pkg::OP_RETURN, 0, 0);
    `CHK("return cycles", w_idle + 1, ex_wait);
    // Accesses outside the map are ignored and read back as zero.
    ahb(1'b1, 32'h0000_0400, 32'h0000_00FF);
    ahb(1'b0, 32'h0000_0400, 32'h0);
    `CHK("unmapped read", 0, rd);
    ahb(1'b0, ra(cmr_pkg::IDX_ACC) | 32'h1, 32'h0);
    `CHK("misaligned read", 0, rd);
    $display("test returns done");
    repeat (600) @(posedge core_clk);
    ahb(1'b0, ra(cmr_pkg::IDX_WDOG), 32'h0);
    `CHK("watchdog running", 1, rd != 0);
    exec(cmr_pkg::OP_SLEEP, 0, 0);
    `CHK("osc in sleep", 0, osc_run);
    ahb(1'b0, ra(cmr_pkg::IDX_WDOG), 32'h0);
    `CHK("watchdog cleared", 0, rd);
    // An opcode written while asleep is stored but never runs.
    ahb(1'b1, ra(cmr_pkg::IDX_OPCODE), 32'h0000_3A5A);
    `CHK("osc still stopped", 0, osc_run);
    m_slp = 0;
    wr_status(m_c, m_z, m_gie, 1);
    // The wake lands at the data-phase edge, so look one edge later.
    @(posedge core_clk);
    `CHK("osc after wake", 1, osc_run);
    // A cleared prescaler needs a full 256 clocks before the first tick.
    repeat (200) @(posedge core_clk);
    ahb(1'b0, ra(cmr_pkg::IDX_WDOG), 32'h0);
    `CHK("prescaler cleared", 0, rd);
    repeat (100) @(posedge core_clk);
    ahb(1'b0, ra(cmr_pkg::IDX_WDOG), 32'h0);
    `CHK("watchdog first tick", 1, rd);
    check_all(0);
    `CHK("bus response", 0, hresp);
    $display("test sleep done");
    end_sim();
  end

  // Watchdog: the tests need a few thousand cycles at most.
  initial begin
    repeat (30000) @(posedge core_clk);
    fails++;
    $display("Error watchdog expected finish seen timeout");
    end_sim();
  end
endmodule : cpu_move_return_rotate_sleep_ops_tb_top
`default_nettype wire
